// >>> hw/spi_eeprom_params.svh
// constants of the serial eeprom command decoder and status register
// assumes inclusion by the package and the decoder, by bare name
`ifndef SPI_EEPROM_PARAMS_SVH
`define SPI_EEPROM_PARAMS_SVH
// instruction codes with the don't-care bit 3 cleared
`define OPC_DC_MASK 8'hf7
`define OPC_SET_WE 8'h06
`define OPC_CLR_WE 8'h04
`define OPC_STAT_RD 8'h05
`define OPC_STAT_WR 8'h01
`define OPC_ARR_RD 8'h03
`define OPC_ARR_WR 8'h02
`define OPC_ID_RD 8'h83
`define OPC_ID_WR 8'h82
// status byte field positions
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1
`define ST_SEL_LO_BIT 2
`define ST_SEL_HI_BIT 3
`define ST_HWPEN_BIT 7
`define ST_WRITING_VAL 8'hff
// reset and shipped values
`define WEL_RESET 1'b0
`define SEL_SHIPPED 2'b00
`define HWPEN_SHIPPED 1'b0
// address decode
`define ADDR_PAGE_SEL_BIT 10
`define LOCK_DATA_BIT 1
`define SEL_NONE 2'b00
`define SEL_QUARTER 2'b01
`define SEL_HALF 2'b10
`define SEL_ALL 2'b11
`define QUARTER_BASE 14'h3000
`define HALF_BASE 14'h2000
// frame bit counts
`define OPC_LAST_BIT 4'h7
`define ADDR_LAST_BIT 4'hf
`define STAT_BYTE_BITS 4'h8
// self-timed write cycle
`define T_WR_NS 5000000
`define CLK_SYS_NS 20
`define WR_CYC ((`T_WR_NS) / (`CLK_SYS_NS))
`endif

// >>> hw/spi_eeprom_pkg.sv
// types and the instruction decode of the serial eeprom command block
// assumes the constants header sits beside it
`include "spi_eeprom_params.svh"
package spi_eeprom_pkg;
  typedef enum logic [1:0] {PH_OPC, PH_ADDR, PH_DATA} phase_e;
  typedef enum logic [1:0] {WK_ARRAY, WK_ID, WK_LOCK} write_kind_e;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_SET_WE, CMD_CLR_WE, CMD_STAT_RD, CMD_STAT_WR,
    CMD_ARR_RD, CMD_ARR_WR, CMD_ID_RD, CMD_ID_WR, CMD_LOCK
  } cmd_e;

  // bit 3 ignored; shared code 1000x010 splits on address bit 10
  function automatic cmd_e decode_cmd(input logic [7:0] opc, input logic sel);
    logic [7:0] m;
    m = opc & `OPC_DC_MASK;
    decode_cmd = CMD_NONE;
    if (m == `OPC_SET_WE) decode_cmd = CMD_SET_WE;
    else if (m == `OPC_CLR_WE) decode_cmd = CMD_CLR_WE;
    else if (m == `OPC_STAT_RD) decode_cmd = CMD_STAT_RD;
    else if (m == `OPC_STAT_WR) decode_cmd = CMD_STAT_WR;
    else if (m == `OPC_ARR_RD) decode_cmd = CMD_ARR_RD;
    else if (m == `OPC_ARR_WR) decode_cmd = CMD_ARR_WR;
    else if (m == `OPC_ID_RD && !sel) decode_cmd = CMD_ID_RD;
    else if (m == `OPC_ID_WR) decode_cmd = sel ? CMD_LOCK : CMD_ID_WR;
  endfunction : decode_cmd
endpackage : spi_eeprom_pkg

// >>> hw/spi_eeprom_status_opcode_decode.sv
// serial eeprom slave: frame shifter, instruction decode, status register
// assumes SCK stops while CS_N is high and CS_N stays high for 4 CLK_SYS
// cycles between frames; RD_DATA follows RD_ADDR within half an SCK period
`timescale 1ns/10ps
`default_nettype none
`include "spi_eeprom_params.svh"

module spi_eeprom_status_opcode_decode #(
  parameter int WR_CYC = `WR_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  input wire logic WP_N,
  input wire logic ID_LOCKED,
  input wire logic [2:0] NV_RESTORE,
  input wire logic [7:0] RD_DATA,
  output logic SO_O,
  output logic SO_OE,
  output logic [15:0] RD_ADDR,
  output logic RD_ID_PAGE,
  output logic BUSY,
  output logic WRITE_ENABLE,
  output logic [1:0] PROTECT_SEL,
  output logic HW_PROTECT_ENABLE,
  output logic WRITE_GO,
  output logic [1:0] WRITE_KIND,
  output logic [15:0] WRITE_ADDR,
  output logic WRITE_BLOCKED
);

  localparam logic [17:0] WR_LAST = 18'(WR_CYC - 1);

  // link side (SCK)
  logic start_ff;
  spi_eeprom_pkg::phase_e phase_ff;
  logic [3:0] cnt_ff;
  logic [7:0] op_ff;
  logic [15:0] addr_ff;
  logic [7:0] dat_ff;
  logic dbyte_ff;
  logic frame_tgl_ff;
  logic [15:0] rd_addr_ff;
  logic rd_id_ff;
  logic so_ff;
  logic so_oe_ff;
  spi_eeprom_pkg::cmd_e cmd_w;
  logic talk_w;
  logic [7:0] out_byte_w;

  // system side (CLK_SYS)
  logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
  logic wp_s1_ff, wp_s2_ff;
  logic tg_s1_ff, tg_s2_ff, tg_seen_ff;
  logic wel_ff;
  logic [1:0] prot_sel_ff;
  logic hw_protect_enable_ff;
  logic restored_ff;
  logic busy_ff;
  logic [17:0] tmr_ff;
  logic pend_stat_ff;
  logic [7:0] pend_ff;
  logic [7:0] stat_view_ff;
  logic lock_view_ff;
  logic go_ff;
  logic [1:0] kind_ff;
  logic [15:0] waddr_ff;
  logic blocked_ff;
  logic commit_w, hwp_w, op_only_w, one_byte_w, with_data_w;
  logic acc_status_write_cmd_w, acc_arr_w, acc_id_w, acc_lock_w, go_start_w;
  logic blk_w;

  // shared decode; its inputs only move while a frame is running
  assign cmd_w = spi_eeprom_pkg::decode_cmd(op_ff, addr_ff[`ADDR_PAGE_SEL_BIT]);

  // frame start flag: raised by chip select high, dropped by first rising edge
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      start_ff <= 1'b1;
    end else begin
      start_ff <= 1'b0;
    end
  end

  // input shifter: rising edge, msb first, opcode then address then data
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      phase_ff <= spi_eeprom_pkg::PH_OPC;
      cnt_ff <= 4'h0;
      op_ff <= 8'h00;
      addr_ff <= 16'h0000;
      dat_ff <= 8'h00;
      dbyte_ff <= 1'b0;
      frame_tgl_ff <= 1'b0;
    end else if (start_ff) begin
      phase_ff <= spi_eeprom_pkg::PH_OPC;
      cnt_ff <= 4'h1;
      op_ff <= {7'h00, SI};
      dbyte_ff <= 1'b0;
      frame_tgl_ff <= ~frame_tgl_ff; // frame marker crossing to CLK_SYS
    end else begin
      unique case (phase_ff)
        spi_eeprom_pkg::PH_OPC: begin
          op_ff <= {op_ff[6:0], SI};
          if (cnt_ff == `OPC_LAST_BIT) begin
            phase_ff <= spi_eeprom_pkg::PH_ADDR;
            cnt_ff <= 4'h0;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        spi_eeprom_pkg::PH_ADDR: begin
          addr_ff <= {addr_ff[14:0], SI};
          if (cnt_ff == `ADDR_LAST_BIT) begin
            phase_ff <= spi_eeprom_pkg::PH_DATA;
            cnt_ff <= 4'h0;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        spi_eeprom_pkg::PH_DATA: begin
          dat_ff <= {dat_ff[6:0], SI};
          if (cnt_ff == `OPC_LAST_BIT) begin
            dbyte_ff <= 1'b1;
            cnt_ff <= 4'h0;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
      endcase
    end
  end

  // read address: loaded with the last address bit, stepped per byte
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      rd_addr_ff <= 16'h0000;
      rd_id_ff <= 1'b0;
    end else if (phase_ff == spi_eeprom_pkg::PH_ADDR && cnt_ff == `ADDR_LAST_BIT) begin
      rd_addr_ff <= {addr_ff[14:0], SI};
      // address bit 10 is still one place short in the shifter at this edge
      rd_id_ff <= ((op_ff & `OPC_DC_MASK) == `OPC_ID_RD)
                  && !addr_ff[`ADDR_PAGE_SEL_BIT - 1];
    end else if (phase_ff == spi_eeprom_pkg::PH_DATA && cnt_ff == `OPC_LAST_BIT) begin
      // id page stays inside its 64 bytes, the array rolls over whole
      if (rd_id_ff) begin
        rd_addr_ff <= {rd_addr_ff[15:6], rd_addr_ff[5:0] + 6'h01};
      end else begin
        rd_addr_ff <= rd_addr_ff + 16'h0001;
      end
    end
  end

  // output phase choice; stale phase of the previous frame is masked by start
  always_comb begin
    talk_w = 1'b0;
    out_byte_w = RD_DATA;
    if (!start_ff) begin
      if (cmd_w == spi_eeprom_pkg::CMD_STAT_RD) begin
        talk_w = (phase_ff != spi_eeprom_pkg::PH_OPC);
        out_byte_w = stat_view_ff;
      end else if (phase_ff == spi_eeprom_pkg::PH_DATA && !stat_view_ff[`ST_BUSY_BIT]) begin
        talk_w = (cmd_w == spi_eeprom_pkg::CMD_ARR_RD) || (cmd_w == spi_eeprom_pkg::CMD_ID_RD)
                 || (cmd_w == spi_eeprom_pkg::CMD_LOCK);
        if (cmd_w == spi_eeprom_pkg::CMD_LOCK) begin
          out_byte_w = {7'h00, lock_view_ff};
        end
      end
    end
  end

  // serial output on falling edge; chip select high forces high impedance
  always_ff @(negedge SCK or posedge CS_N) begin
    if (CS_N) begin
      so_oe_ff <= 1'b0;
      so_ff <= 1'b0;
    end else begin
      so_oe_ff <= talk_w;
      so_ff <= out_byte_w[3'h7 - cnt_ff[2:0]];
    end
  end

  // two-flop synchronisers of chip select, protect pin and frame marker
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
      wp_s1_ff <= 1'b1;
      wp_s2_ff <= 1'b1;
      tg_s1_ff <= 1'b0;
      tg_s2_ff <= 1'b0;
      tg_seen_ff <= 1'b0;
    end else begin
      cs_s1_ff <= CS_N;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
      wp_s1_ff <= WP_N;
      wp_s2_ff <= wp_s1_ff;
      tg_s1_ff <= frame_tgl_ff;
      tg_s2_ff <= tg_s1_ff;
      if (cs_s2_ff && !cs_s3_ff) begin
        tg_seen_ff <= tg_s2_ff;
      end
    end
  end

  // end of frame: shift registers are frozen once chip select is high
  assign commit_w = cs_s2_ff && !cs_s3_ff && (tg_s2_ff != tg_seen_ff) && !busy_ff;
  assign hwp_w = hw_protect_enable_ff && !wp_s2_ff;
  assign op_only_w = (phase_ff == spi_eeprom_pkg::PH_ADDR) && (cnt_ff == 4'h0);
  assign one_byte_w = (phase_ff == spi_eeprom_pkg::PH_ADDR) && (cnt_ff == `STAT_BYTE_BITS);
  assign with_data_w = (phase_ff == spi_eeprom_pkg::PH_DATA) && dbyte_ff && (cnt_ff == 4'h0);
  assign acc_status_write_cmd_w = commit_w && cmd_w == spi_eeprom_pkg::CMD_STAT_WR && one_byte_w
                      && wel_ff && !hwp_w;
  assign acc_arr_w = commit_w && cmd_w == spi_eeprom_pkg::CMD_ARR_WR && with_data_w
                     && wel_ff;
  assign acc_id_w = commit_w && cmd_w == spi_eeprom_pkg::CMD_ID_WR && with_data_w
                    && wel_ff && !lock_view_ff;
  assign acc_lock_w = commit_w && cmd_w == spi_eeprom_pkg::CMD_LOCK && with_data_w && wel_ff
                      && prot_sel_ff != `SEL_ALL && !lock_view_ff
                      && dat_ff[`LOCK_DATA_BIT];
  assign go_start_w = acc_status_write_cmd_w || acc_arr_w || acc_id_w || acc_lock_w;

  // block protection compare on the 14-bit array address
  always_comb begin
    unique case (prot_sel_ff)
      `SEL_NONE: blk_w = 1'b0;
      `SEL_QUARTER: blk_w = (addr_ff[13:0] >= `QUARTER_BASE);
      `SEL_HALF: blk_w = (addr_ff[13:0] >= `HALF_BASE);
      `SEL_ALL: blk_w = 1'b1;
    endcase
  end

  // write enable latch
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wel_ff <= `WEL_RESET;
    end else if (commit_w) begin
      if (cmd_w == spi_eeprom_pkg::CMD_SET_WE && op_only_w) begin
        wel_ff <= 1'b1;
      end else if (cmd_w == spi_eeprom_pkg::CMD_CLR_WE && op_only_w) begin
        wel_ff <= 1'b0;
      end else if (acc_status_write_cmd_w || acc_arr_w) begin
        wel_ff <= 1'b0;
      end
    end
  end

  // self-timed write cycle; busy returns to standby on expiry
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      busy_ff <= 1'b0;
      tmr_ff <= 18'h00000;
    end else if (go_start_w) begin
      busy_ff <= 1'b1;
      tmr_ff <= 18'h00000;
    end else if (busy_ff) begin
      if (tmr_ff == WR_LAST) begin
        busy_ff <= 1'b0;
      end else begin
        tmr_ff <= tmr_ff + 18'h00001;
      end
    end
  end

  // stored status fields; the status byte lands only when its cycle ends
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      prot_sel_ff <= `SEL_SHIPPED;
      hw_protect_enable_ff <= `HWPEN_SHIPPED;
      restored_ff <= 1'b0;
      pend_stat_ff <= 1'b0;
      pend_ff <= 8'h00;
    end else if (!restored_ff) begin
      prot_sel_ff <= NV_RESTORE[1:0];
      hw_protect_enable_ff <= NV_RESTORE[2];
      restored_ff <= 1'b1;
    end else if (acc_status_write_cmd_w) begin
      pend_stat_ff <= 1'b1;
      pend_ff <= addr_ff[7:0]; // bits 4 to 6 dropped below
    end else if (pend_stat_ff && busy_ff && tmr_ff == WR_LAST) begin
      pend_stat_ff <= 1'b0;
      prot_sel_ff <= {pend_ff[`ST_SEL_HI_BIT], pend_ff[`ST_SEL_LO_BIT]};
      // protect pin may have fallen during the cycle: keep enable set
      hw_protect_enable_ff <= pend_ff[`ST_HWPEN_BIT] || hwp_w;
    end
  end

  // status image for the link; refreshed only between frames so it is stable
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      stat_view_ff <= 8'h00;
      lock_view_ff <= 1'b0;
    end else if (cs_s2_ff) begin
      lock_view_ff <= ID_LOCKED;
      if (busy_ff || go_start_w) begin
        stat_view_ff <= `ST_WRITING_VAL;
      end else begin
        stat_view_ff <= {hw_protect_enable_ff, 3'h0, prot_sel_ff, wel_ff, 1'b0};
      end
    end
  end

  // write request towards the array sequencer, one cycle pulse
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      go_ff <= 1'b0;
      kind_ff <= spi_eeprom_pkg::WK_ARRAY;
      waddr_ff <= 16'h0000;
      blocked_ff <= 1'b0;
    end else begin
      go_ff <= acc_arr_w || acc_id_w || acc_lock_w;
      if (acc_arr_w || acc_id_w || acc_lock_w) begin
        waddr_ff <= addr_ff;
        // hardware protection never reaches the array
        blocked_ff <= acc_arr_w && blk_w;
        if (acc_arr_w) begin
          kind_ff <= spi_eeprom_pkg::WK_ARRAY;
        end else if (acc_id_w) begin
          kind_ff <= spi_eeprom_pkg::WK_ID;
        end else begin
          kind_ff <= spi_eeprom_pkg::WK_LOCK;
        end
      end
    end
  end

  assign SO_O = so_ff;
  assign SO_OE = so_oe_ff;
  assign RD_ADDR = rd_addr_ff;
  assign RD_ID_PAGE = rd_id_ff;
  assign BUSY = busy_ff;
  assign WRITE_ENABLE = wel_ff;
  assign PROTECT_SEL = prot_sel_ff;
  assign HW_PROTECT_ENABLE = hw_protect_enable_ff;
  assign WRITE_GO = go_ff;
  assign WRITE_KIND = kind_ff;
  assign WRITE_ADDR = waddr_ff;
  assign WRITE_BLOCKED = blocked_ff;

  // checks
  sequence s_set_we;
    commit_w && cmd_w == spi_eeprom_pkg::CMD_SET_WE && op_only_w;
  endsequence
  sequence s_cycle_start;
    !busy_ff ##1 busy_ff;
  endsequence

  property p_set_we;
    @(posedge CLK_SYS) disable iff (!RST_N) s_set_we |=> wel_ff;
  endproperty
  a_set_we: assert property (p_set_we) else $error("latch not set");

  property p_clr_we;
    @(posedge CLK_SYS) disable iff (!RST_N)
      commit_w && cmd_w == spi_eeprom_pkg::CMD_CLR_WE && op_only_w |=> !wel_ff;
  endproperty
  a_clr_we: assert property (p_clr_we) else $error("latch not cleared");

  property p_busy_ignores;
    @(posedge CLK_SYS) disable iff (!RST_N)
      busy_ff && cs_s2_ff && !cs_s3_ff |=> $stable(wel_ff) && !go_ff;
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("busy accepted command");

  property p_hwp_locks;
    @(posedge CLK_SYS) disable iff (!RST_N)
      hwp_w && !busy_ff && restored_ff |=> $stable(prot_sel_ff);
  endproperty
  a_hwp_locks: assert property (p_hwp_locks) else $error("status changed");

  property p_no_latch_no_write;
    @(posedge CLK_SYS) disable iff (!RST_N) !wel_ff |=> !go_ff;
  endproperty
  a_no_latch_no_write: assert property (p_no_latch_no_write) else $error("write w/o latch");

  property p_go_pulse;
    @(posedge CLK_SYS) disable iff (!RST_N) go_ff |=> !go_ff && busy_ff;
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("request not a pulse");

  property p_all_blocked;
    @(posedge CLK_SYS) disable iff (!RST_N)
      acc_arr_w && prot_sel_ff == `SEL_ALL |=> blocked_ff && !wel_ff;
  endproperty
  a_all_blocked: assert property (p_all_blocked) else $error("array not protected");

  property p_hwpen_hold;
    @(posedge CLK_SYS) disable iff (!RST_N)
      restored_ff && hw_protect_enable_ff && !wp_s2_ff |=> hw_protect_enable_ff;
  endproperty
  a_hwpen_hold: assert property (p_hwpen_hold) else $error("enable dropped");

  property p_busy_min;
    @(posedge CLK_SYS) disable iff (!RST_N) s_cycle_start |-> busy_ff [*2];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("cycle too short");

  property p_view_ones;
    @(posedge CLK_SYS) disable iff (!RST_N)
      busy_ff && cs_s2_ff |=> stat_view_ff == `ST_WRITING_VAL;
  endproperty
  a_view_ones: assert property (p_view_ones) else $error("status not all ones");

  property p_so_quiet;
    @(negedge SCK) disable iff (CS_N) start_ff |=> !so_oe_ff;
  endproperty
  a_so_quiet: assert property (p_so_quiet) else $error("output driven early");

endmodule : spi_eeprom_status_opcode_decode
`default_nettype wire

// >>> testbench/spi_eeprom_status_opcode_decode_test.sv
// self-checking bench of the eeprom decoder and status register
// assumes the master model file is compiled first
`timescale 1ns/10ps
`default_nettype none

module spi_eeprom_status_opcode_decode_test;
  localparam int WR = 60;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic WP_N = 1'b1;
  logic ID_LOCKED = 1'b0;
  logic [2:0] NV_RESTORE = 3'b001;
  logic [7:0] RD_DATA;
  logic CS_N, SCK, SI, SO_O, SO_OE, RD_ID_PAGE, BUSY, WRITE_ENABLE;
  logic HW_PROTECT_ENABLE, WRITE_GO, WRITE_BLOCKED;
  logic [15:0] RD_ADDR, WRITE_ADDR;
  logic [1:0] PROTECT_SEL, WRITE_KIND;
  int failures = 0;
  int tests_run = 0;
  int go_cnt = 0;
  logic [18:0] go_info = '0;

  always #10 CLK_SYS = ~CLK_SYS;
  // memory stand-in: byte is a fixed function of its address
  always_comb RD_DATA = RD_ADDR[7:0] ^ 8'h5a;

  spi_master_model m (.CS_N(CS_N), .SCK(SCK), .SI(SI), .SO_O(SO_O), .SO_OE(SO_OE));

  spi_eeprom_status_opcode_decode #(.WR_CYC(WR)) uut (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CS_N(CS_N), .SCK(SCK), .SI(SI),
    .WP_N(WP_N), .ID_LOCKED(ID_LOCKED), .NV_RESTORE(NV_RESTORE),
    .RD_DATA(RD_DATA), .SO_O(SO_O), .SO_OE(SO_OE), .RD_ADDR(RD_ADDR),
    .RD_ID_PAGE(RD_ID_PAGE), .BUSY(BUSY), .WRITE_ENABLE(WRITE_ENABLE),
    .PROTECT_SEL(PROTECT_SEL), .HW_PROTECT_ENABLE(HW_PROTECT_ENABLE),
    .WRITE_GO(WRITE_GO), .WRITE_KIND(WRITE_KIND), .WRITE_ADDR(WRITE_ADDR),
    .WRITE_BLOCKED(WRITE_BLOCKED));

  // capture each write start; the pulse lasts one cycle only
  always @(posedge CLK_SYS) begin
    if (WRITE_GO === 1'b1) begin
      go_cnt <= go_cnt + 1;
      go_info <= {WRITE_BLOCKED, WRITE_KIND, WRITE_ADDR};
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic cmd(input logic [31:0] tx, input int n);
    logic [31:0] rx;
    m.frame(tx, n, 1'b0, rx);
  endtask : cmd

  task automatic st(input logic idle, input logic [7:0] exp);
    logic [31:0] rx;
    m.frame(32'h0000_0500, 16, idle, rx);
    chk("status byte", rx[7:0], exp);
    chk("so enable", SO_OE, 1'b0);
  endtask : st

  // bounded wait for the self-timed cycle to end
  task automatic wait_idle();
    for (int i = 0; i < 4 * WR && BUSY !== 1'b0; i++) @(posedge CLK_SYS);
    @(posedge CLK_SYS);
  endtask : wait_idle

  task automatic t_reset();
    chk("latch", WRITE_ENABLE, 1'b0);
    chk("sel", PROTECT_SEL, 2'b01);
    chk("hwpen", HW_PROTECT_ENABLE, 1'b0);
    st(1'b0, 8'h04);
    $display("test reset done");
  endtask : t_reset

  task automatic t_latch();
    cmd(32'h07, 8);
    chk("undefined op", WRITE_ENABLE, 1'b0);
    cmd(32'h0e, 8);
    chk("set latch bit3", WRITE_ENABLE, 1'b1);
    st(1'b1, 8'h06);
    cmd(32'h04, 8);
    chk("clear latch", WRITE_ENABLE, 1'b0);
    $display("test latch done");
  endtask : t_latch

  task automatic t_status();
    cmd(32'h018c, 16);
    wait_idle();
    chk("status_write_cmd no latch", PROTECT_SEL, 2'b01);
    chk("busy end", BUSY, 1'b0);
    cmd(32'h06, 8);
    cmd(32'h01fc, 16);
    chk("busy", BUSY, 1'b1);
    st(1'b0, 8'hff);
    cmd(32'h06, 8);
    chk("set_write_enable_cmd in busy", WRITE_ENABLE, 1'b0);
    wait_idle();
    chk("sel set", PROTECT_SEL, 2'b11);
    chk("hwpen set", HW_PROTECT_ENABLE, 1'b1);
    st(1'b0, 8'h8c);
    @(posedge CLK_SYS) WP_N <= 1'b0;
    cmd(32'h06, 8);
    cmd(32'h0100, 16);
    wait_idle();
    chk("hwpen held", HW_PROTECT_ENABLE, 1'b1);
    chk("sel held", PROTECT_SEL, 2'b11);
    @(posedge CLK_SYS) WP_N <= 1'b1;
    cmd(32'h06, 8);
    cmd(32'h0100, 16);
    wait_idle();
    chk("hwpen clear", HW_PROTECT_ENABLE, 1'b0);
    $display("test status done");
  endtask : t_status

  task automatic t_write();
    logic [15:0] a[4] = '{16'h1fff, 16'h2000, 16'h2fff, 16'h3000};
    logic b;
    int g;
    g = go_cnt;
    cmd({8'h02, 16'h0100, 8'ha5}, 32);
    chk("write no latch", go_cnt, g);
    for (int s = 3; s >= 0; s--) begin
      cmd(32'h06, 8);
      cmd({16'h0000, 8'h01, 8'(s << 2)}, 16);
      wait_idle();
      for (int k = 0; k < 4; k++) begin
        b = (s == 3) || (s == 2 && a[k] >= 16'h2000) || (s == 1 && a[k] >= 16'h3000);
        g = go_cnt;
        cmd(32'h06, 8);
        cmd({8'h02, a[k], 8'ha5}, 32);
        chk("write go", go_cnt, g + 1);
        chk("write info", go_info, {b, 2'b00, a[k]});
        chk("latch after write", WRITE_ENABLE, 1'b0);
        wait_idle();
      end
    end
    $display("test write done");
  endtask : t_write

  task automatic t_read();
    logic [31:0] rx;
    int g;
    m.frame({8'h03, 16'h1234, 8'h00}, 32, 1'b0, rx);
    chk("array read", rx[7:0], 8'h34 ^ 8'h5a);
    chk("array flag", RD_ID_PAGE, 1'b0);
    chk("so idle", SO_OE, 1'b0);
    cmd(32'h06, 8);
    cmd({8'h82, 16'h0005, 8'h11}, 32);
    chk("id write", go_info, {1'b0, 2'b01, 16'h0005});
    wait_idle();
    cmd(32'h06, 8);
    cmd({8'h82, 16'h0400, 8'h02}, 32);
    chk("page lock", go_info[17:16], 2'b10);
    wait_idle();
    m.frame({8'h83, 16'h0005, 8'h00}, 32, 1'b0, rx);
    chk("id read", rx[7:0], 8'h05 ^ 8'h5a);
    chk("id page flag", RD_ID_PAGE, 1'b1);
    @(posedge CLK_SYS) ID_LOCKED <= 1'b1;
    m.frame({8'h82, 16'h0400, 8'h00}, 32, 1'b1, rx);
    chk("lock status", rx[7:0], 8'h01);
    g = go_cnt;
    cmd(32'h06, 8);
    cmd({8'h82, 16'h0005, 8'h11}, 32);
    chk("locked id write", go_cnt, g);
    $display("test read done");
  endtask : t_read

  // watchdog: the whole sequence needs well under this span
  initial begin
    #400us;
    failures++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (5) @(posedge CLK_SYS);
    t_reset();
    t_latch();
    t_status();
    t_write();
    t_read();
    end_of_test();
  end
endmodule : spi_eeprom_status_opcode_decode_test
`default_nettype wire

// >>> testbench/spi_master_model.sv
// serial master model: drives chip select, serial clock and data in
// assumes one frame at a time, called from the bench's top module
`timescale 1ns/10ps
`default_nettype none

module spi_master_model (
  output logic CS_N,
  output logic SCK,
  output logic SI,
  input wire logic SO_O,
  input wire logic SO_OE
);
  logic so_last = 1'b0;
  logic so_w;

  // released line toggles so a stale bit never passes for data
  always_comb so_w = SO_OE ? SO_O : ~so_last;
  always @(posedge SCK) so_last <= so_w;

  initial begin
    CS_N = 1'b1;
    SCK = 1'b0;
    SI = 1'b0;
  end

  // idle selects clock mode 0 or 3; clock stands still between frames unless the mode changes
  task automatic frame(input logic [31:0] tx, input int n, input logic idle,
                       output logic [31:0] rx);
    rx = '0;
    SCK = idle;
    #6 CS_N = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #6 SCK = 1'b0;
      SI = tx[i]; // msb first
      #6 SCK = 1'b1;
      rx[i] = so_w;
    end
    #6 SCK = idle;
    #2 CS_N = 1'b1; // byte boundary, before any further rise
    SI = ~SI;
    #100; // deselect gap well above four system cycles
  endtask : frame
endmodule : spi_master_model
`default_nettype wire
